// ==== rtl/dafc_pkg.sv ====
package dafc_pkg;
  // Frame layout and sizes; edge counts are in serial clock falling edges
  localparam int unsigned RES_BITS     = 12;
  localparam int unsigned FRAME_LEN    = 32;
  localparam int unsigned DATA_EDGES   = 14;
  localparam int unsigned PD_LO_EDGES  = 2;
  localparam int unsigned PD_HI_EDGES  = 10;
  localparam int unsigned EDGE_CNT_W   = 6;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned SYNC_PINS    = 7;
  // Values after reset
  localparam logic [2:0]  ADDR_RST     = 3'h0;
  localparam logic        PIN_HIGH_RST = 1'h1;
  localparam logic [5:0]  EDGE_CNT_RST = 6'h00;

  typedef enum logic [1:0] {
    DAFC_NORMAL,
    DAFC_PARTIAL_PD,
    DAFC_FULL_PD
  } dafc_mode_type;
endpackage

// ==== rtl/dafc_fifo.sv ====
`timescale 1ns/1ns
module dafc_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("dafc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             ready_q;
  wire              push  = in_valid && in_ready;
  wire              pop   = out_valid && out_ready;
  wire  [AW:0]      wr_nx = wr_q + {{AW{1'b0}}, push};
  wire  [AW:0]      rd_nx = rd_q + {{AW{1'b0}}, pop};

  // Ready registered ahead from next pointers; empty from extended pointers
  assign in_ready  = ready_q;
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // Pointer and ready update
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_q    <= '0;
      rd_q    <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_q    <= wr_nx;
      rd_q    <= rd_nx;
      ready_q <= (wr_nx - rd_nx) != DEPTH[AW:0];
    end
  end

  // Storage
  always_ff @(posedge CLK) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end

  no_push_full_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_q - rd_q) == DEPTH[AW:0] |-> !in_ready)
    else $error("fifo accepts while full");
  ready_free_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_q - rd_q) != DEPTH[AW:0] |-> in_ready)
    else $error("fifo refuses while not full");
  count_tracks_a : assert property (@(posedge CLK) disable iff (!RST_N)
    push && !pop |=> (wr_q - rd_q) == $past(wr_q - rd_q) + 1'b1)
    else $error("fifo count did not grow on push");
endmodule

// ==== rtl/dafc_frame.sv ====
`timescale 1ns/1ns
// Summary of operation
// RL1 - Straight binary only single-ended/pseudo, single range
// RL2 - Config high: address 0-5 picks input vs ground
// RL3 - Config low: upper bits pair, bit0 pseudo
// RL4 - Chip select fall samples; clock edges time frame
// RL5 - Three power modes chosen by rise edge count
// RL6 - Host holds select low ten edges for power
// RL7 - Rise edges 10-13: stay powered, abort, release
// RL8 - Full result needs fourteen serial clock cycles
// RL9 - After fourteen keep driving until rise or 32
// RL10 - Two more cycles give two trailing zeros
// RL11 - Further cycles shift second result same line (code: line A only, line B shifts zeros)
// RL12 - Release line at 32nd edge or rise
// RL13 - Host may idle select low after 32
// RL14 - Host restarts only after release and quiet gap
// RL15 - Range pin low single, high double range
// RL16 - Host holds config until sampler tracks again
// RL17 - Rise edges 2-9 abort, partial power-down
// RL18 - Rise edges 2-9 from partial: full power-down
// RL19 - Capture address, config, range at select fall
module dafc_frame #(
  parameter int unsigned RES_W   = dafc_pkg::RES_BITS,
  parameter int unsigned FIFO_D  = dafc_pkg::FIFO_DEPTH
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               CS_N,
  input  wire logic               SCLK,
  input  wire logic               CHANNEL_ADDR_BIT0,
  input  wire logic               CHANNEL_ADDR_BIT1,
  input  wire logic               CHANNEL_ADDR_BIT2,
  input  wire logic               INPUT_CONFIG_SELECT,
  input  wire logic               RANGE_SELECT,
  input  wire logic               RESULT_VALID,
  output logic                    RESULT_READY,
  input  wire logic [RES_W-1:0]   RESULT_A,
  input  wire logic [RES_W-1:0]   RESULT_B,
  output logic                    RESULT_LINE_A,
  output logic                    RESULT_LINE_A_OE,
  output logic                    RESULT_LINE_B,
  output logic                    RESULT_LINE_B_OE,
  output logic                    SAMPLE_START,
  output logic                    CONV_ABORT,
  output logic [2:0]              POS_INPUT,
  output logic [2:0]              NEG_INPUT,
  output logic                    NEG_IS_GROUND,
  output logic                    FULLY_DIFF,
  output logic                    TWOS_COMPLEMENT,
  output logic [1:0]              POWER_MODE
);
  if (RES_W != dafc_pkg::RES_BITS || FIFO_D < 2) begin : g_bad
    $error("dafc_frame: frame layout needs 12-bit results and FIFO depth >= 2");
  end

  localparam int unsigned W  = dafc_pkg::FRAME_LEN;
  localparam int unsigned CW = dafc_pkg::EDGE_CNT_W;
  localparam logic [CW-1:0] N_LAST = CW'(dafc_pkg::FRAME_LEN);
  localparam logic [CW-1:0] N_DATA = CW'(dafc_pkg::DATA_EDGES);
  localparam logic [CW-1:0] N_LO   = CW'(dafc_pkg::PD_LO_EDGES);
  localparam logic [CW-1:0] N_HI   = CW'(dafc_pkg::PD_HI_EDGES);

  // Pin synchronisers: three stages, a change counts when 2 and 3 agree
  wire  [dafc_pkg::SYNC_PINS-1:0] pin_raw = {RANGE_SELECT, INPUT_CONFIG_SELECT,
    CHANNEL_ADDR_BIT2, CHANNEL_ADDR_BIT1, CHANNEL_ADDR_BIT0, SCLK, CS_N};
  logic [dafc_pkg::SYNC_PINS-1:0] pin_filt;

  for (genvar i = 0; i < dafc_pkg::SYNC_PINS; i++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic f_q;
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        s1_q <= dafc_pkg::PIN_HIGH_RST;
        s2_q <= dafc_pkg::PIN_HIGH_RST;
        s3_q <= dafc_pkg::PIN_HIGH_RST;
        f_q  <= dafc_pkg::PIN_HIGH_RST;
      end else begin
        s1_q <= pin_raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) f_q <= s3_q;
      end
    end
    assign pin_filt[i] = f_q;
  end

  // Edge detection on filtered chip select and serial clock
  logic cs_prev_q;
  logic sclk_prev_q;
  wire  cs_f      = pin_filt[0];
  wire  sclk_f    = pin_filt[1];
  wire  [2:0] addr_f = pin_filt[4:2];
  wire  cfg_f     = pin_filt[5];
  wire  range_f   = pin_filt[6];
  wire  cs_fall   = cs_prev_q && !cs_f;
  wire  cs_rise   = !cs_prev_q && cs_f;
  wire  sclk_fall = sclk_prev_q && !sclk_f;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_prev_q   <= dafc_pkg::PIN_HIGH_RST;
      sclk_prev_q <= dafc_pkg::PIN_HIGH_RST;
    end else begin
      cs_prev_q   <= cs_f;
      sclk_prev_q <= sclk_f;
    end
  end

  // Result pairs queue up ahead of the frame
  logic               fifo_valid;
  logic [2*RES_W-1:0] fifo_data;
  logic               fifo_ready_in;

  dafc_fifo #(.WIDTH(2 * RES_W), .DEPTH(FIFO_D)) u_fifo (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .in_valid  (RESULT_VALID),
    .in_ready  (fifo_ready_in),
    .in_data   ({RESULT_A, RESULT_B}),
    .out_valid (fifo_valid),
    .out_ready (cs_fall),
    .out_data  (fifo_data)
  );
  assign RESULT_READY = fifo_ready_in;

  // Decode of live pins, used at the select fall
  wire          sgl_in    = cfg_f;
  wire          pseudo_in = !cfg_f && addr_f[0];
  wire          twos_in   = !((sgl_in || pseudo_in) && !range_f);             // [RL1] [RL15]
  wire [2:0]    pos_in    = sgl_in ? addr_f : {addr_f[2:1], 1'b0};          // [RL2] [RL3]
  wire [2:0]    neg_in    = sgl_in ? 3'h0 : {addr_f[2:1], 1'b1};            // [RL3]
  wire [RES_W-1:0] code_a = twos_in ? {~fifo_data[2*RES_W-1], fifo_data[2*RES_W-2:RES_W]}
                                    : fifo_data[2*RES_W-1:RES_W];
  wire [RES_W-1:0] code_b = twos_in ? {~fifo_data[RES_W-1], fifo_data[RES_W-2:0]}
                                    : fifo_data[RES_W-1:0];
  wire [RES_W-1:0] pick_a = fifo_valid ? code_a : '0;
  wire [RES_W-1:0] pick_b = fifo_valid ? code_b : '0;
  // Two leads, data, two trailing zeros, then the other converter on line A, zeros on line B
  wire [W-1:0]  load_a = {2'b00, pick_a, 2'b00, 2'b00, pick_b, 2'b00};      // [RL10] [RL11]
  wire [W-1:0]  load_b = {2'b00, pick_b, 2'b00, 16'h0000};

  // Captured configuration for the whole frame
  logic [2:0] pos_q;
  logic [2:0] neg_q;
  logic       gnd_q;
  logic       fdiff_q;
  logic       twos_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_q   <= dafc_pkg::ADDR_RST;
      neg_q   <= dafc_pkg::ADDR_RST;
      gnd_q   <= dafc_pkg::PIN_HIGH_RST;
      fdiff_q <= 1'b0;
      twos_q  <= 1'b0;
    end else if (cs_fall) begin                                               // [RL19]
      pos_q   <= pos_in;
      neg_q   <= neg_in;
      gnd_q   <= sgl_in;
      fdiff_q <= !sgl_in && !addr_f[0];
      twos_q  <= twos_in;
    end
  end

  // Falling edge counter and line shifters
  logic [CW-1:0] edges_q;
  logic          active_q;
  logic          oe_q;
  logic [W-1:0]  sh_a_q;
  logic [W-1:0]  sh_b_q;
  wire  [CW-1:0] edges_nx = edges_q + 1'b1;
  wire           last_edge = active_q && sclk_fall && edges_nx == N_LAST;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      edges_q  <= dafc_pkg::EDGE_CNT_RST;
      active_q <= 1'b0;
      oe_q     <= 1'b0;
      sh_a_q   <= '0;
      sh_b_q   <= '0;
    end else if (cs_fall) begin                                               // [RL4]
      edges_q  <= dafc_pkg::EDGE_CNT_RST;
      active_q <= 1'b1;
      oe_q     <= 1'b1;
      sh_a_q   <= load_a;
      sh_b_q   <= load_b;
    end else if (cs_rise) begin                                               // [RL7] [RL12]
      active_q <= 1'b0;
      oe_q     <= 1'b0;
    end else if (active_q && sclk_fall) begin
      if (edges_q != N_LAST) edges_q <= edges_nx;
      sh_a_q <= {sh_a_q[W-2:0], 1'b0};
      sh_b_q <= {sh_b_q[W-2:0], 1'b0};
      if (last_edge) oe_q <= 1'b0;                                            // [RL9] [RL12]
    end
  end

  // Power mode and abort pulse at the select rise, sample pulse at the select fall
  dafc_pkg::dafc_mode_type mode_q;
  dafc_pkg::dafc_mode_type mode_d;
  logic start_q;
  logic abort_q;
  wire  in_pd_window = edges_q >= N_LO && edges_q < N_HI;
  wire  abort_now    = cs_rise && active_q && edges_q >= N_LO && edges_q < N_DATA;

  always_comb begin
    mode_d = mode_q;
    if (cs_rise && active_q) begin                                            // [RL5]
      if (edges_q >= N_HI) begin
        mode_d = dafc_pkg::DAFC_NORMAL;                                       // [RL6]
      end else if (in_pd_window) begin
        unique case (mode_q)
          dafc_pkg::DAFC_NORMAL:     mode_d = dafc_pkg::DAFC_PARTIAL_PD;      // [RL17]
          dafc_pkg::DAFC_PARTIAL_PD: mode_d = dafc_pkg::DAFC_FULL_PD;         // [RL18]
          dafc_pkg::DAFC_FULL_PD:    mode_d = dafc_pkg::DAFC_FULL_PD;
          default:                   mode_d = dafc_pkg::DAFC_NORMAL;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q  <= dafc_pkg::DAFC_NORMAL;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      start_q <= cs_fall;
      abort_q <= abort_now;                                                   // [RL7] [RL8]
    end
  end

  // Ports straight from flip-flops
  assign RESULT_LINE_A    = sh_a_q[W-1];
  assign RESULT_LINE_B    = sh_b_q[W-1];
  assign RESULT_LINE_A_OE = oe_q;
  assign RESULT_LINE_B_OE = oe_q;
  assign SAMPLE_START     = start_q;
  assign CONV_ABORT       = abort_q;
  assign POS_INPUT        = pos_q;
  assign NEG_INPUT        = neg_q;
  assign NEG_IS_GROUND    = gnd_q;
  assign FULLY_DIFF       = fdiff_q;
  assign TWOS_COMPLEMENT  = twos_q;
  assign POWER_MODE       = mode_q;

  // Checks
  sequence frame_open_s;
    cs_fall;
  endsequence
  sequence line_driven_s;
    RESULT_LINE_A_OE && RESULT_LINE_B_OE;
  endsequence

  open_drives_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL4]
    frame_open_s |=> line_driven_s and SAMPLE_START)
    else $error("lines not driven after select fall");
  start_pulse_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL4]
    SAMPLE_START |=> !SAMPLE_START)
    else $error("sample pulse longer than one cycle");
  rise_release_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL12]
    cs_rise |=> !RESULT_LINE_A_OE && !RESULT_LINE_B_OE)
    else $error("lines still driven after select rise");
  edge32_release_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL12]
    last_edge && !cs_fall && !cs_rise |=> !oe_q && edges_q == N_LAST)
    else $error("lines not released at 32nd edge");
  hold_after14_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL9]
    oe_q && !cs_rise && !cs_fall && edges_q >= N_DATA && edges_nx != N_LAST
    |=> oe_q)
    else $error("line released early after 14 edges");
  trail_zeros_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL10]
    oe_q && (edges_q == N_DATA || edges_q == N_DATA + 1'b1)
    |-> !RESULT_LINE_A && !RESULT_LINE_B)
    else $error("trailing bits not zero");
  late_rise_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL8]
    cs_rise && active_q && edges_q >= N_DATA
    |=> !CONV_ABORT && POWER_MODE == dafc_pkg::DAFC_NORMAL)
    else $error("full frame treated as abort");
  coding_pick_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL1]
    cs_fall && cfg_f && !range_f |=> !TWOS_COMPLEMENT)
    else $error("straight binary not chosen");
  single_decode_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL2]
    cs_fall && cfg_f |=> POS_INPUT == $past(addr_f) && NEG_IS_GROUND)
    else $error("single-ended decode wrong");
  pair_decode_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL3]
    cs_fall && !cfg_f |=> NEG_INPUT == POS_INPUT + 3'h1
    && FULLY_DIFF == !$past(addr_f[0]))
    else $error("pair decode wrong");
  enter_partial_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL17]
    cs_rise && active_q && in_pd_window && mode_q == dafc_pkg::DAFC_NORMAL
    |=> POWER_MODE == dafc_pkg::DAFC_PARTIAL_PD && !RESULT_LINE_A_OE)
    else $error("partial power-down not entered");
  enter_full_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL18]
    cs_rise && active_q && in_pd_window && mode_q == dafc_pkg::DAFC_PARTIAL_PD
    |=> POWER_MODE == dafc_pkg::DAFC_FULL_PD)
    else $error("full power-down not entered");
  stay_powered_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL7]
    cs_rise && active_q && edges_q >= N_HI && edges_q < N_DATA
    |=> POWER_MODE == dafc_pkg::DAFC_NORMAL && CONV_ABORT)
    else $error("abort after tenth edge wrong");
  glitch_keep_a : assert property (@(posedge CLK) disable iff (!RST_N) // [RL5]
    cs_rise && edges_q < N_LO |=> $stable(POWER_MODE))
    else $error("mode changed on early rise");
endmodule

// ==== dv/dafc_host.sv ====
`timescale 1ns/1ns
module dafc_host (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  input  wire logic line_a,
  input  wire logic oe_a,
  input  wire logic line_b,
  input  wire logic oe_b
);
  logic [31:0] bits_a;
  logic [31:0] bits_b;
  logic        oe_held;
  int          n_falls;

  // Bus idle: select and serial clock high, clock still outside frames
  initial begin
    cs_n    = 1'h1;
    sclk    = 1'h1;
    n_falls = 0;
  end

  // One frame of k clock falls; a released line reads as unknown
  task automatic frame(input int k);
    @(negedge clk);
    cs_n    = 1'h0;
    n_falls = 0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < k; i++) begin
      bits_a  = {bits_a[30:0], oe_a ? line_a : 1'hX};
      bits_b  = {bits_b[30:0], oe_b ? line_b : 1'hX};
      sclk    = 1'h0;
      n_falls = n_falls + 1;
      repeat (6) @(negedge clk);
      sclk = 1'h1;
      repeat (6) @(negedge clk);
    end
    oe_held = oe_a & oe_b;
    cs_n    = 1'h1;                // rise count chosen by caller
    repeat (12) @(negedge clk);    // release plus quiet gap
  endtask
endmodule

// ==== dv/dual_adc_frame_control_tb.sv ====
`timescale 1ns/1ns
module dual_adc_frame_control_tb;
  typedef struct packed {
    logic       cfg;
    logic [2:0] addr;
    logic       rng;
    logic [2:0] pos;
    logic [2:0] neg;
    logic       gnd;
    logic       fd;
    logic       tc;
  } dafc_row_type;

  logic         clk;
  logic         rst_n;
  logic         cs_n;
  logic         sclk;
  logic [2:0]   addr;
  logic         cfg;
  logic         rng;
  logic         r_valid;
  logic         r_ready;
  logic [11:0]  res_a;
  logic [11:0]  res_b;
  logic         line_a;
  logic         oe_a;
  logic         line_b;
  logic         oe_b;
  logic         s_start;
  logic         abort;
  logic [2:0]   pos;
  logic [2:0]   neg;
  logic         gnd;
  logic         fd;
  logic         tc;
  logic [1:0]   mode;
  logic [11:0]  ea;
  logic [11:0]  eb;
  int           err_total = 0;
  int           n_checks = 0;
  int           n_start = 0;
  int           n_abort = 0;
  int           s0;
  int           a0;
  dafc_row_type rows [12];
  int           pk [7] = '{12, 5, 1, 5, 1, 10, 5};
  logic [1:0]   pm [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1};

  dafc_frame dut (
    .CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
    .CHANNEL_ADDR_BIT0(addr[0]), .CHANNEL_ADDR_BIT1(addr[1]), .CHANNEL_ADDR_BIT2(addr[2]),
    .INPUT_CONFIG_SELECT(cfg), .RANGE_SELECT(rng), .RESULT_VALID(r_valid),
    .RESULT_READY(r_ready), .RESULT_A(res_a), .RESULT_B(res_b),
    .RESULT_LINE_A(line_a), .RESULT_LINE_A_OE(oe_a), .RESULT_LINE_B(line_b),
    .RESULT_LINE_B_OE(oe_b), .SAMPLE_START(s_start), .CONV_ABORT(abort),
    .POS_INPUT(pos), .NEG_INPUT(neg), .NEG_IS_GROUND(gnd), .FULLY_DIFF(fd),
    .TWOS_COMPLEMENT(tc), .POWER_MODE(mode)
  );
  dafc_host host (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .line_a(line_a), .oe_a(oe_a),
    .line_b(line_b), .oe_b(oe_b)
  );

  // Clock, 40 ns period
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Pulse counters
  always @(negedge clk) begin
    if (s_start === 1'h1) n_start <= n_start + 1;
    if (abort === 1'h1) n_abort <= n_abort + 1;
  end

  // Watchdog
  initial begin
    #1000000;
    check(32'h0, 32'h1, "watchdog");
    finish_test();
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Coding as shifted out
  function automatic logic [11:0] cod(input logic [11:0] x, input logic t);
    return t ? {~x[11], x[10:0]} : x;
  endfunction

  // One result pair into the buffer, held until taken
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    @(negedge clk);
    r_valid = 1'h1;
    res_a   = a;
    res_b   = b;
    for (int w = 0; w < 50 && r_ready !== 1'h1; w++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    r_valid = 1'h0;
  endtask

  // Verdict
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n   = 1'h0;
    addr    = 3'h0;
    cfg     = 1'h1;
    rng     = 1'h0;
    r_valid = 1'h0;
    res_a   = 12'h000;
    res_b   = 12'h000;
    rows[0]  = '{1'h1, 3'h0, 1'h0, 3'h0, 3'h0, 1'h1, 1'h0, 1'h0};
    rows[1]  = '{1'h1, 3'h1, 1'h1, 3'h1, 3'h0, 1'h1, 1'h0, 1'h1};
    rows[2]  = '{1'h1, 3'h2, 1'h0, 3'h2, 3'h0, 1'h1, 1'h0, 1'h0};
    rows[3]  = '{1'h1, 3'h3, 1'h1, 3'h3, 3'h0, 1'h1, 1'h0, 1'h1};
    rows[4]  = '{1'h1, 3'h4, 1'h0, 3'h4, 3'h0, 1'h1, 1'h0, 1'h0};
    rows[5]  = '{1'h1, 3'h5, 1'h1, 3'h5, 3'h0, 1'h1, 1'h0, 1'h1};
    rows[6]  = '{1'h0, 3'h0, 1'h0, 3'h0, 3'h1, 1'h0, 1'h1, 1'h1};
    rows[7]  = '{1'h0, 3'h1, 1'h0, 3'h0, 3'h1, 1'h0, 1'h0, 1'h0};
    rows[8]  = '{1'h0, 3'h2, 1'h1, 3'h2, 3'h3, 1'h0, 1'h1, 1'h1};
    rows[9]  = '{1'h0, 3'h3, 1'h1, 3'h2, 3'h3, 1'h0, 1'h0, 1'h1};
    rows[10] = '{1'h0, 3'h4, 1'h0, 3'h4, 3'h5, 1'h0, 1'h1, 1'h1};
    rows[11] = '{1'h0, 3'h5, 1'h1, 3'h4, 3'h5, 1'h0, 1'h0, 1'h1};
    repeat (2) @(negedge clk);
    check(mode, 2'h0, "reset mode");
    check(oe_a | oe_b, 1'h0, "reset drive");
    rst_n = 1'h1;
    // Table rows: pins flipped mid-frame, full dual read
    for (int i = 0; i < 12; i++) begin
      {cfg, addr, rng} = {rows[i].cfg, rows[i].addr, rows[i].rng};
      ea = 12'hF00 | 12'(i);
      eb = 12'h0A0 | 12'(i);
      push(ea, eb);
      repeat (6) @(negedge clk);
      s0 = n_start;
      a0 = n_abort;
      fork
        host.frame(32);
        begin
          wait (host.n_falls == 16);
          @(negedge clk);
          {cfg, addr, rng} = ~{cfg, addr, rng};
        end
      join
      check(pos, rows[i].pos, "positive input");
      check(neg, rows[i].neg, "negative input");
      check(gnd, rows[i].gnd, "ground");
      check(fd, rows[i].fd, "fully diff");
      check(tc, rows[i].tc, "coding");
      check(host.bits_a, {2'h0, cod(ea, rows[i].tc), 4'h0, cod(eb, rows[i].tc), 2'h0},
            "line a");
      check(host.bits_b, {2'h0, cod(eb, rows[i].tc), 18'h0}, "line b");
      check(host.oe_held, 1'h0, "release at 32");
      check(n_start - s0, 1, "sample");
      check(n_abort - a0, 0, "no abort");
      check(mode, 2'h0, "normal");
    end
    // Short read with trailing zeros, line held until select rises
    {cfg, addr, rng} = 5'h10;
    push(12'h7FF, 12'h800);
    repeat (6) @(negedge clk);
    host.frame(16);
    check(host.bits_a[15:0], {2'h0, 12'h7FF, 2'h0}, "trailing");
    check(host.oe_held, 1'h1, "held after 14");
    check(oe_a, 1'h0, "released on rise");
    // Select idles low past the 32nd edge, bus already released
    host.frame(34);
    check(host.oe_held, 1'h0, "idle low after 32");
    check(mode, 2'h0, "normal after idle low");
    // Early rises: abort and power mode steps
    for (int i = 0; i < 7; i++) begin
      a0 = n_abort;
      host.frame(pk[i]);
      check(mode, pm[i], "power mode");
      check(n_abort - a0, (pk[i] >= 2), "abort");
      check(oe_a | oe_b, 1'h0, "released");
    end
    // Reset in mid-run
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    check(mode, 2'h0, "mode after reset");
    rst_n = 1'h1;
    // Fill the buffer until it refuses, then drain it
    for (int j = 0; j < 8; j++) push(12'h100 + 12'(j), 12'h000);
    @(negedge clk);
    r_valid = 1'h1;
    repeat (3) @(negedge clk);
    check(r_ready, 1'h0, "buffer full");
    r_valid = 1'h0;
    for (int j = 0; j < 8; j++) begin
      host.frame(14);
      check(host.bits_a[13:0], {2'h0, 12'h100 + 12'(j)}, "drain");
    end
    check(r_ready, 1'h1, "buffer free");
    host.frame(14);
    check(host.bits_a[13:0], 14'h0000, "empty buffer");
    finish_test();
  end
endmodule
